// ### hw/tla_alert.sv
// Purpose: conversion sequencing, limit comparison and alert pin control
// Assumes: converter results arrive on their own clock; serial slave lives elsewhere
// Notes: remote values are 16-bit left-justified, low five bits always zero
`timescale 1ns/10ps
`include "tla_defs.svh"

module tla_alert #(
  parameter int unsigned CONV_CYC = `TLA_CONV_CYC,
  parameter int unsigned TMO_CYC = `TLA_TMO_CYC,
  parameter int unsigned TACH_W = 16
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic link_rstn_in,
  input wire tla_pkg::tla_rdg_s adc_rdg_in,
  input wire logic adc_valid_in,
  input wire tla_pkg::tla_lim_s limits_in,
  input wire logic [7:0] conv_rate_in,
  input wire logic standby_in,
  input wire logic pwm_stby_dis_in,
  input wire logic pin_sel_in,
  input wire logic comp_mode_in,
  input wire logic mask_wr_in,
  input wire logic mask_wr_data_in,
  input wire logic status_rd_in,
  input wire logic smbclk_in,
  input wire logic smbdat_in,
  input wire logic alert_tach_in,
  output logic alert_tach_out,
  output logic alert_tach_oe_n_out,
  output logic mask_out,
  output logic [7:0] status_out,
  output logic [7:0] local_reading_out,
  output logic [7:0] remote_reading_hi_out,
  output logic [7:0] remote_reading_lo_out,
  output logic conv_start_out,
  output logic pwm_run_out,
  output logic [TACH_W-1:0] tach_period_out,
  output logic smb_if_reset_out
);
  import tla_pkg::*;

  // link domain: capture a result and hand it over by toggle handshake
  tla_rdg_s hold_q;
  logic req_q, ack_s1_q, ack_s2_q;
  logic ack_q;

  always_ff @(posedge link_clk_in) begin
    if (!link_rstn_in) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // a result arriving while the previous is unacknowledged is dropped;
  // results come every few tens of ms so this never bites in practice
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn_in) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (adc_valid_in && (req_q == ack_s2_q)) begin
      req_q <= ~req_q;
      hold_q <= adc_rdg_in;
    end
  end

  // core domain
  logic req_s1_q, req_s2_q;
  tla_rdg_s rdg_q;
  logic new_rdg;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  assign new_rdg = req_s2_q != ack_q;

  // hold_q is stable while the toggles differ, so sampling it here is safe
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      rdg_q <= '0;
    end else if (new_rdg) begin
      ack_q <= req_s2_q;
      rdg_q <= hold_q;
    end
  end

  // pin synchronisers
  logic [2:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
    end else begin
      pin_s1_q <= {alert_tach_in, smbdat_in, smbclk_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // conversion sequencer
  tla_seq_e state_q;
  logic [31:0] tmr_q;
  logic [7:0] units_q;
  logic conv_end;

  assign conv_end = (state_q == TLA_CONVERT) && (tmr_q == CONV_CYC - 1);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_q <= TLA_CONVERT;
      tmr_q <= '0;
      units_q <= '0;
    end else begin
      case (state_q)
        TLA_STANDBY: begin
          tmr_q <= '0;
          if (!standby_in) begin
            state_q <= TLA_CONVERT;
          end
        end
        TLA_CONVERT: begin
          if (conv_end) begin
            tmr_q <= '0;
            units_q <= conv_rate_in;
            if (standby_in) begin
              state_q <= TLA_STANDBY;
            end else if (conv_rate_in != 8'h00) begin
              state_q <= TLA_IDLE_WAIT;
            end
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        default: begin
          // idle delay in whole conversion lengths, set by the rate code
          if (standby_in) begin
            state_q <= TLA_STANDBY;
            tmr_q <= '0;
          end else if (tmr_q == CONV_CYC - 1) begin
            tmr_q <= '0;
            units_q <= units_q - 8'h1;
            if (units_q == 8'h1) begin
              state_q <= TLA_CONVERT;
            end
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
      endcase
    end
  end

  // start pulse on each entry to a conversion
  tla_seq_e state_prev_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_prev_q <= TLA_STANDBY;
    end else begin
      state_prev_q <= state_q;
    end
  end

  assign conv_start_out = (state_q == TLA_CONVERT) &&
                          ((state_prev_q != TLA_CONVERT) || (tmr_q == '0));

  assign pwm_run_out = !(state_q == TLA_STANDBY && pwm_stby_dis_in);

  // remote value with offset, low bits forced clear
  logic [15:0] rem_adj;
  logic [15:0] crit16, hyst16;

  assign rem_adj = ({rdg_q.remote_raw, 5'h00} + limits_in.remote_offset) &
                   `TLA_REM_LSB_MASK;
  assign crit16 = {limits_in.critical_limit, 8'h00};
  assign hyst16 = {limits_in.hysteresis_value, 8'h00};

  logic lhigh_raw, rhigh_raw, rlow_raw, rcrit_raw;

  assign lhigh_raw = $signed(rdg_q.local_reading) > $signed(limits_in.local_high_limit);
  assign rhigh_raw = $signed(rem_adj) > $signed(limits_in.remote_high_limit);
  assign rlow_raw = $signed(rem_adj) < $signed(limits_in.remote_low_limit);
  assign rcrit_raw = $signed(rem_adj) > $signed(crit16);

  // readings published at the end of each conversion
  logic [15:0] rem_q;
  logic [7:0] loc_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rem_q <= '0;
      loc_q <= '0;
    end else if (conv_end) begin
      rem_q <= rem_adj;
      loc_q <= rdg_q.local_reading;
    end
  end

  assign local_reading_out = loc_q;
  assign remote_reading_hi_out = rem_q[15:8];
  assign remote_reading_lo_out = rem_q[7:0];

  // comparator conditions with hysteresis on the high-side limits
  logic lhigh_q, rhigh_q, rlow_q, rcrit_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      lhigh_q <= 1'b0;
      rhigh_q <= 1'b0;
      rlow_q <= 1'b0;
      rcrit_q <= 1'b0;
    end else if (conv_end) begin
      lhigh_q <= lhigh_raw || (lhigh_q && ($signed(rdg_q.local_reading) >=
                 $signed(limits_in.local_high_limit - limits_in.hysteresis_value)));
      rhigh_q <= rhigh_raw || (rhigh_q &&
                 ($signed(rem_adj) >= $signed(limits_in.remote_high_limit - hyst16)));
      rcrit_q <= rcrit_raw || (rcrit_q && ($signed(rem_adj) >= $signed(crit16 - hyst16)));
      rlow_q <= rlow_raw;
    end
  end

  // sticky status, a new violation in the read cycle survives the clear
  logic [7:0] sticky_q;
  logic [7:0] sticky_set;

  always_comb begin
    sticky_set = 8'h00;
    if (conv_end) begin
      sticky_set[`TLA_ST_LHIGH] = lhigh_raw;
      sticky_set[`TLA_ST_RHIGH] = rhigh_raw;
      sticky_set[`TLA_ST_RLOW] = rlow_raw;
      sticky_set[`TLA_ST_RCRIT] = rcrit_raw;
      sticky_set[`TLA_ST_OPEN] = rdg_q.diode_open;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sticky_q <= `TLA_STATUS_RST;
    end else if (status_rd_in) begin
      sticky_q <= sticky_set;
    end else begin
      sticky_q <= sticky_q | sticky_set;
    end
  end

  logic [7:0] status_view;
  logic alarms;

  always_comb begin
    status_view = sticky_q;
    status_view[`TLA_ST_BUSY] = (state_q == TLA_CONVERT);
  end

  assign alarms = |(sticky_q & `TLA_ST_ALARMS);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      status_out <= `TLA_STATUS_RST;
    end else begin
      status_out <= status_view;
    end
  end

  // mask bit: device set on a status read with alarms pending, unless in comparator mode, wins over a host write
  logic mask_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      mask_q <= 1'b0;
    end else if (status_rd_in && !comp_mode_in && alarms) begin
      mask_q <= 1'b1;
    end else if (mask_wr_in) begin
      mask_q <= mask_wr_data_in;
    end
  end

  assign mask_out = mask_q;

  // alert pin drive
  logic cond_any, alert_drv_q;

  assign cond_any = lhigh_q || rhigh_q || rlow_q || rcrit_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      alert_drv_q <= 1'b0;
    end else begin
      // select, mask and style all gate the pull-down
      alert_drv_q <= !pin_sel_in && !mask_q &&
                     (comp_mode_in ? cond_any : alarms);
    end
  end

  assign alert_tach_out = 1'b0;
  assign alert_tach_oe_n_out = !alert_drv_q;

  // tach period: core cycles between rising pulse edges, saturating
  logic tach_prev_q;
  logic [TACH_W-1:0] tach_cnt_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tach_prev_q <= 1'b1;
      tach_cnt_q <= '0;
      tach_period_out <= `TLA_TACH_RST;
    end else if (pin_sel_in) begin
      tach_prev_q <= pin_s2_q[2];
      if (pin_s2_q[2] && !tach_prev_q) begin
        tach_period_out <= tach_cnt_q;
        tach_cnt_q <= '0;
      end else if (tach_cnt_q != '1) begin
        tach_cnt_q <= tach_cnt_q + 1'b1;
      end
    end else begin
      tach_prev_q <= 1'b1;
      tach_cnt_q <= '0;
    end
  end

  // serial timeout: either line low too long
  logic [31:0] tmo_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tmo_q <= '0;
      smb_if_reset_out <= 1'b0;
    end else if (pin_s2_q[0] && pin_s2_q[1]) begin
      tmo_q <= '0;
      smb_if_reset_out <= 1'b0;
    end else if (tmo_q == TMO_CYC - 1) begin
      tmo_q <= '0;
      smb_if_reset_out <= 1'b1;
    end else begin
      tmo_q <= tmo_q + 32'h1;
      smb_if_reset_out <= 1'b0;
    end
  end
endmodule

// ### hw/tla_defs.svh
// Purpose: constants for the temperature limit and alert block
// Assumes: core clock of 200 MHz
// Notes: status bit positions are local to this block
`ifndef TLA_DEFS_SVH
`define TLA_DEFS_SVH

`define TLA_CLK_MHZ 200
`define TLA_CONV_US 31250
`define TLA_CONV_CYC (`TLA_CONV_US * `TLA_CLK_MHZ)
`define TLA_TMO_MS 30
`define TLA_TMO_CYC (`TLA_TMO_MS * 1000 * `TLA_CLK_MHZ)

`define TLA_ST_BUSY 7
`define TLA_ST_LHIGH 6
`define TLA_ST_RHIGH 4
`define TLA_ST_RLOW 3
`define TLA_ST_OPEN 2
`define TLA_ST_RCRIT 1
`define TLA_ST_ALARMS 8'h5a

`define TLA_REM_LSB_MASK 16'hffe0
`define TLA_STATUS_RST 8'h00
`define TLA_TACH_RST 16'h0000

`endif

// ### hw/tla_pkg.sv
// Purpose: types for the temperature limit and alert block
// Assumes: nothing
// Notes: constants live in tla_defs.svh
package tla_pkg;
  typedef struct packed {
    logic [7:0] local_reading;
    logic [10:0] remote_raw;
    logic diode_open;
  } tla_rdg_s;

  typedef struct packed {
    logic [7:0] local_high_limit;
    logic [15:0] remote_high_limit;
    logic [15:0] remote_low_limit;
    logic [7:0] critical_limit;
    logic [7:0] hysteresis_value;
    logic [15:0] remote_offset;
  } tla_lim_s;

  typedef enum logic [1:0] {
    TLA_STANDBY,
    TLA_CONVERT,
    TLA_IDLE_WAIT
  } tla_seq_e;
endpackage

// ### test/tb_tla_alert.sv
// Purpose: directed checks of tla_alert
// Assumes: short conversion and timeout counts
// Notes: readings come from tla_adc_model
`timescale 1ns/10ps
module tb_tla_alert;
  import tla_pkg::*;
  typedef struct packed {
    logic [7:0] loc;
    logic [10:0] raw;
    logic [15:0] off;
    logic [7:0] st;
    logic [15:0] rem;
  } tla_case_s;
  localparam tla_case_s CASES [10] = '{
    {8'h14, 11'h0f0, 16'h0000, 8'h00, 16'h1e00}, {8'h1e, 11'h0f0, 16'h0000, 8'h40, 16'h1e00},
    {8'h14, 11'h1b8, 16'h0000, 8'h10, 16'h3700}, {8'h14, 11'h258, 16'h0000, 8'h12, 16'h4b00},
    {8'h14, 11'h7f8, 16'h0000, 8'h08, 16'hff00}, {8'h14, 11'h0f1, 16'h0000, 8'h00, 16'h1e20},
    {8'h14, 11'h0f0, 16'h1500, 8'h10, 16'h3300}, {8'h14, 11'h0f0, 16'hff00, 8'h00, 16'h1d00},
    {8'h19, 11'h0f0, 16'h0000, 8'h00, 16'h1e00}, {8'h19, 11'h190, 16'h0000, 8'h00, 16'h3200}};
  localparam logic [10:0] CMP [3] = '{11'h1b8, 11'h178, 11'h140};
  logic clk, lclk, rstn, lrstn, adc_v, stby, pdis, sel, comp, mwr, mdat, srd, sclk, sdat, tach;
  logic oe_n, mask, cst, prun, sres;
  logic [7:0] rate, st, lr, rh, rl;
  logic [15:0] tper;
  tla_rdg_s rdg, adc;
  tla_lim_s lim;
  tla_case_s c;
  int failures, tests_run, n;
  realtime t0;
  tla_adc_model u_adc (.link_clk_in(lclk), .link_rstn_in(lrstn), .rdg_in(rdg),
    .rdg_out(adc), .valid_out(adc_v));
  tla_alert #(.CONV_CYC(200), .TMO_CYC(100)) DUT (
    .core_clk_in(clk), .rstn_in(rstn), .link_clk_in(lclk), .link_rstn_in(lrstn),
    .adc_rdg_in(adc), .adc_valid_in(adc_v), .limits_in(lim), .conv_rate_in(rate),
    .standby_in(stby), .pwm_stby_dis_in(pdis), .pin_sel_in(sel), .comp_mode_in(comp),
    .mask_wr_in(mwr), .mask_wr_data_in(mdat), .status_rd_in(srd), .smbclk_in(sclk),
    .smbdat_in(sdat), .alert_tach_in(tach & oe_n), .alert_tach_out(),
    .alert_tach_oe_n_out(oe_n),
    .mask_out(mask), .status_out(st), .local_reading_out(lr), .remote_reading_hi_out(rh),
    .remote_reading_lo_out(rl), .conv_start_out(cst), .pwm_run_out(prun),
    .tach_period_out(tper), .smb_if_reset_out(sres));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_conv(input int k);
    repeat (k) @(posedge clk iff cst);
  endtask
  task automatic rd_status();
    @(posedge clk);
    srd <= 1'b1;
    @(posedge clk);
    srd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr_mask(input logic v);
    @(posedge clk);
    mwr <= 1'b1;
    mdat <= v;
    @(posedge clk);
    mwr <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  initial begin
    lrstn = 1'b0;
    repeat (3) @(posedge lclk);
    lrstn <= 1'b1;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    {rstn, stby, pdis, sel, comp, mwr, mdat, srd} = '0;
    sclk = 1'b1;
    sdat = 1'b1;
    tach = 1'b1;
    rate = 8'h00;
    failures = 0;
    tests_run = 0;
    rdg = {8'h14, 11'h0f0, 1'b0};
    lim = {8'h19, 16'h3200, 16'h0a00, 8'h46, 8'h05, 16'h0000};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("mask", 0, mask);
    chk("pin", 1, oe_n);
    for (int i = 0; i < 10; i++) begin
      c = CASES[i];
      @(posedge clk);
      lim.remote_offset <= c.off;
      rdg.local_reading <= c.loc;
      rdg.remote_raw <= c.raw;
      wait_conv(3);
      rd_status();
      wr_mask(1'b0);
      wait_conv(2);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("status", c.st, st & 8'h5a);
      chk("alert", c.st == 8'h00, oe_n);
      chk("local", c.loc, lr);
      chk("remote", c.rem, {rh, rl});
      rd_status();
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("mask set", c.st != 8'h00, mask);
      chk("masked pin", 1, oe_n);
    end
    @(posedge clk);
    comp <= 1'b1;
    // local must drop below limit minus hysteresis, else its held condition keeps the pin low
    rdg.local_reading <= 8'h0a;
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      rdg.remote_raw <= CMP[j];
      wait_conv(3);
      @(negedge clk);
      chk("compare", j == 2, oe_n);
    end
    @(posedge clk);
    comp <= 1'b0;
    rdg.remote_raw <= 11'h1b8;
    sel <= 1'b1;
    wait_conv(3);
    @(negedge clk);
    chk("tach mode", 1, oe_n);
    // rising edges 20 cycles apart; the count holds the cycles strictly between them
    repeat (4) begin
      @(posedge clk);
      tach <= 1'b0;
      repeat (9) @(posedge clk);
      tach <= 1'b1;
      repeat (10) @(posedge clk);
    end
    @(negedge clk);
    chk("tach period", 16'(20 - 1), tper);
    @(posedge clk);
    sel <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("alert mode", 0, oe_n);
    @(posedge clk);
    stby <= 1'b1;
    pdis <= 1'b1;
    repeat (250) @(posedge clk);
    n = 0;
    repeat (600) begin
      @(negedge clk);
      n += cst;
    end
    chk("standby", 0, 16'(n));
    chk("pwm halt", 0, prun);
    @(posedge clk);
    pdis <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pwm run", 1, prun);
    @(posedge clk);
    stby <= 1'b0;
    n = 0;
    repeat (10) begin
      @(negedge clk);
      n += cst;
    end
    chk("resume", 1, 16'(n));
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      rate <= 8'(r);
      wait_conv(2);
      t0 = $realtime;
      wait_conv(1);
      chk("gap", 16'((r + 1) * 200), 16'(int'(($realtime - t0) / 5.0)));
    end
    @(posedge clk);
    sclk <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!sres && n < 300);
    chk("timeout", 1, n >= 100 && n <= 110);
    @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    sdat <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!sres && n < 300);
    chk("data timeout", 1, n >= 100 && n <= 110);
    @(posedge clk);
    sdat <= 1'b1;
    summarize();
  end
endmodule

// ### test/tla_adc_model.sv
// Purpose: converter stand-in on the link clock
// Assumes: link clock free running
// Notes: data shows junk between results
`timescale 1ns/10ps
module tla_adc_model (
  input wire logic link_clk_in,
  input wire logic link_rstn_in,
  input wire tla_pkg::tla_rdg_s rdg_in,
  output tla_pkg::tla_rdg_s rdg_out,
  output logic valid_out
);
  import tla_pkg::*;
  logic [3:0] tick_q;
  // one result about every conversion, slower than the handover
  always_ff @(posedge link_clk_in) begin
    tick_q <= link_rstn_in ? tick_q + 4'h1 : 4'h0;
    valid_out <= link_rstn_in && tick_q == 4'hf;
    rdg_out <= (link_rstn_in && tick_q == 4'hf) ? rdg_in : ~rdg_in;
  end
endmodule

// ### test/tla_alert_props.sv
// Purpose: port checks for tla_alert
// Assumes: core clock domain only
// Notes: bound into every tla_alert
`timescale 1ns/10ps
module tla_alert_props #(
  parameter int unsigned CONV_CYC = 200,
  parameter int unsigned TMO_CYC = 100
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic pin_sel_in,
  input wire logic comp_mode_in,
  input wire logic mask_wr_in,
  input wire logic mask_wr_data_in,
  input wire logic status_rd_in,
  input wire logic smbclk_in,
  input wire logic smbdat_in,
  input wire logic pwm_stby_dis_in,
  input wire logic alert_tach_out,
  input wire logic alert_tach_oe_n_out,
  input wire logic mask_out,
  input wire logic [7:0] status_out,
  input wire logic conv_start_out,
  input wire logic pwm_run_out,
  input wire logic smb_if_reset_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic [31:0] since_q;
  logic [31:0] low_q;
  logic seen_q;
  always_ff @(posedge core_clk_in) begin
    since_q <= conv_start_out ? 32'h0 : since_q + 32'h1;
    seen_q <= rstn_in & (seen_q | conv_start_out);
  end
  // raw low time, so the synchronizer lag only makes it longer
  always_ff @(posedge core_clk_in) begin
    low_q <= (smbclk_in & smbdat_in) ? 32'h0 : low_q + 32'h1;
  end
  a_pin_data_low:
    assert property (alert_tach_out == 1'b0) else $error("alert data not low");
  a_mask_blocks:
    assert property (mask_out && $past(mask_out) |-> alert_tach_oe_n_out)
    else $error("alert driven while masked");
  a_sel_blocks:
    assert property (pin_sel_in && $past(pin_sel_in) |-> alert_tach_oe_n_out)
    else $error("alert driven in tach mode");
  a_alert_follows:
    assert property (!pin_sel_in && !$past(pin_sel_in) && !mask_out && !$past(mask_out)
      && !comp_mode_in && !$past(comp_mode_in)
      |-> alert_tach_oe_n_out == ((status_out & 8'h5a) == 8'h00))
    else $error("alert pin disagrees with status");
  a_read_masks:
    assert property ($rose(status_rd_in) && !comp_mode_in && (status_out & 8'h5a) != 8'h00
      |=> mask_out) else $error("status read did not mask");
  a_mask_write:
    assert property (mask_wr_in && !status_rd_in |=> mask_out == $past(mask_wr_data_in))
    else $error("mask write lost");
  a_conv_gap:
    assert property (conv_start_out && seen_q |-> since_q >= CONV_CYC - 1)
    else $error("conversion cut short");
  a_pwm_runs:
    assert property (!pwm_stby_dis_in && !$past(pwm_stby_dis_in) |-> pwm_run_out)
    else $error("pwm halted without disable");
  a_tmo_wait:
    assert property (smb_if_reset_out |-> low_q >= TMO_CYC) else $error("early bus reset");
  a_tmo_pulse:
    assert property (smb_if_reset_out |=> !smb_if_reset_out) else $error("bus reset too long");
  c_conv: cover property (conv_start_out);
  c_alert: cover property (!alert_tach_oe_n_out);
  c_tmo: cover property (smb_if_reset_out);
endmodule

bind tla_alert tla_alert_props #(.CONV_CYC(CONV_CYC), .TMO_CYC(TMO_CYC)) u_props (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .pin_sel_in(pin_sel_in),
  .comp_mode_in(comp_mode_in), .mask_wr_in(mask_wr_in), .mask_wr_data_in(mask_wr_data_in),
  .status_rd_in(status_rd_in), .smbclk_in(smbclk_in), .smbdat_in(smbdat_in),
  .pwm_stby_dis_in(pwm_stby_dis_in), .alert_tach_out(alert_tach_out),
  .alert_tach_oe_n_out(alert_tach_oe_n_out), .mask_out(mask_out), .status_out(status_out),
  .conv_start_out(conv_start_out), .pwm_run_out(pwm_run_out),
  .smb_if_reset_out(smb_if_reset_out));
